// File: vcr_pkg.sv
package vcr_pkg;

  // channel and switch geometry
  localparam int unsigned VCR_CHANNELS = 64;
  localparam int unsigned VCR_SW_BITS = 10;
  localparam int unsigned VCR_IDX_W = 12;
  localparam int unsigned VCR_FN_W = 3;
  localparam int unsigned VCR_UNIT_W = 6;
  localparam int unsigned VCR_CH_W = 6;

  // global channel indices start at one for the first unit
  localparam logic [VCR_IDX_W-1:0] VCR_GIDX_FIRST = 12'h001;
  localparam logic [VCR_IDX_W:0] VCR_SPAN = 13'h0040;
  localparam logic [VCR_CH_W-1:0] VCR_RELAY_CH = 6'h3F;  // local slot of channel 64

  // the seven control functions, carried as auxiliary relay numbers
  typedef enum logic [VCR_FN_W-1:0] {
    VCR_FN_NONE = 3'h0,
    VCR_FN_PLAY = 3'h1,
    VCR_FN_STOP = 3'h2,
    VCR_FN_REWIND = 3'h3,
    VCR_FN_FFWD = 3'h4,
    VCR_FN_PAUSE = 3'h5,
    VCR_FN_RECORD = 3'h6,
    VCR_FN_EJECT = 3'h7
  } vcr_func_t;

  // indicator timing
  localparam int unsigned VCR_CLK_KHZ = 250000;
  localparam int unsigned VCR_BLINK_HALF_MS = 500;
  localparam int unsigned VCR_PULSE_MS = 50;
  localparam int unsigned VCR_BLINK_CYC = VCR_BLINK_HALF_MS * VCR_CLK_KHZ;
  localparam int unsigned VCR_PULSE_CYC = VCR_PULSE_MS * VCR_CLK_KHZ;
  localparam int unsigned VCR_CNT_W = 27;

endpackage

// File: vcr_indicator.sv
`timescale 1ns/100ps
module vcr_indicator
  import vcr_pkg::*;
#(
  parameter int unsigned BLINK_CYC = VCR_BLINK_CYC,
  parameter int unsigned PULSE_CYC = VCR_PULSE_CYC
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_restart,
  input wire logic i_accept,
  output logic o_led,
  output logic o_awaiting
);

  typedef enum logic [1:0] {
    ST_BLINK = 2'b01,
    ST_IDLE = 2'b10
  } vcr_ind_state_t;

  localparam logic [VCR_CNT_W-1:0] BLINK_LAST = VCR_CNT_W'(BLINK_CYC - 1);
  localparam logic [VCR_CNT_W-1:0] PULSE_LEN = VCR_CNT_W'(PULSE_CYC);

  vcr_ind_state_t state_q, state_d;
  logic [VCR_CNT_W-1:0] cnt_q, cnt_d;
  logic led_q, led_d;
  wire blink_wrap = (cnt_q == BLINK_LAST);
  wire pulse_live = (cnt_q != '0);

  // restart outranks an accept in the same cycle: config just moved under it
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    led_d = led_q;
    if (i_restart) begin
      state_d = ST_BLINK;
      cnt_d = '0;
      led_d = 1'b1;
    end else if (i_accept) begin
      state_d = ST_IDLE;
      cnt_d = PULSE_LEN;
      led_d = 1'b1;
    end else begin
      unique case (state_q)
        ST_BLINK: begin
          cnt_d = blink_wrap ? '0 : cnt_q + 1'b1;
          led_d = blink_wrap ? ~led_q : led_q;
        end
        ST_IDLE: begin
          cnt_d = pulse_live ? cnt_q - 1'b1 : cnt_q;
          led_d = pulse_live && (cnt_q != VCR_CNT_W'(1));
        end
        default: begin
          state_d = ST_BLINK;
          cnt_d = '0;
        end
      endcase
    end
  end

  // power-up lands in the blinking, awaiting-first-command state
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      state_q <= ST_BLINK;
      cnt_q <= '0;
      led_q <= 1'b1;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      led_q <= led_d;
    end
  end

  assign o_led = led_q;
  assign o_awaiting = (state_q == ST_BLINK);

  a_blink_toggle: assert property (@(posedge i_clock) disable iff (i_rst)
    (state_q == ST_BLINK) && blink_wrap && !i_restart && !i_accept
      |=> (led_q != $past(led_q))) else $error("blink did not toggle");
  a_blink_steady: assert property (@(posedge i_clock) disable iff (i_rst)
    (state_q == ST_BLINK) && !blink_wrap && !i_restart && !i_accept
      |=> $stable(led_q)) else $error("blink toggled early");
  a_accept_pulse: assert property (@(posedge i_clock) disable iff (i_rst)
    i_accept && !i_restart |=> (state_q == ST_IDLE) && led_q)
    else $error("accept did not light");
  a_idle_dark: assert property (@(posedge i_clock) disable iff (i_rst)
    (state_q == ST_IDLE) && !pulse_live && !i_accept && !i_restart |=> !led_q)
    else $error("led lit without command");
  a_restart_blink: assert property (@(posedge i_clock) disable iff (i_rst)
    i_restart |=> (state_q == ST_BLINK) && (cnt_q == '0))
    else $error("restart ignored");
  c_blink_wrap: cover property (@(posedge i_clock) disable iff (i_rst)
    (state_q == ST_BLINK) && blink_wrap);

endmodule

// File: vcr_relay_top.sv
// Behaviour
// - blink data led until first accept
// - afterwards pulse led per accepted command only
// - forward commands for units further down
// - forwarded commands never light the data led
// - power, panel reset, switch change restart blinking
// - power led on from power-up
// - relay de-energized at power-up
// - play on channel 64 energizes relay
// - stop on channel 64 de-energizes relay
// - sixty-four addressed recorder control outputs
// - config from two ten-position switch banks
// - seven functions, numbers one to seven
// - downstream port forwards chain traffic
`timescale 1ns/100ps
module vcr_relay_top
  import vcr_pkg::*;
#(
  parameter int unsigned BLINK_CYC = VCR_BLINK_CYC,
  parameter int unsigned PULSE_CYC = VCR_PULSE_CYC
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [VCR_SW_BITS-1:0] i_sw_bank1,
  input wire logic [VCR_SW_BITS-1:0] i_sw_bank2,
  input wire logic i_panel_reset,
  input wire logic i_cmd_valid,
  input wire logic i_cmd_good,
  input wire logic [VCR_IDX_W-1:0] i_cmd_global_channel_index,
  input wire logic [VCR_FN_W-1:0] i_cmd_func,
  output logic o_fwd_valid,
  output logic [VCR_IDX_W-1:0] o_fwd_global_channel_index,
  output logic [VCR_FN_W-1:0] o_fwd_func,
  output logic [VCR_CHANNELS-1:0] o_vcr_strobe,
  output logic [VCR_FN_W-1:0] o_vcr_func,
  output logic o_relay,
  output logic o_power_led,
  output logic o_data_led
);

  // switch and button pins: two flops before any logic looks at them
  logic [2*VCR_SW_BITS:0] pin_meta_q;
  logic [2*VCR_SW_BITS:0] pin_sync_q;
  logic [2*VCR_SW_BITS-1:0] sw_prev_q;

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
    end else begin
      pin_meta_q <= {i_panel_reset, i_sw_bank2, i_sw_bank1};
      pin_sync_q <= pin_meta_q;
    end
  end

  // previous settled switch image, for change detection; the compare stays
  // blind until the image holds a real sample, else every release of reset
  // with non-zero switches would fake a slide move
  localparam int unsigned SW_SETTLE = 3;
  logic [SW_SETTLE-1:0] sw_armed_q;

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      sw_prev_q <= '0;
      sw_armed_q <= '0;
    end else begin
      sw_prev_q <= pin_sync_q[2*VCR_SW_BITS-1:0];
      sw_armed_q <= {sw_armed_q[SW_SETTLE-2:0], 1'b1};
    end
  end

  // any switch slide moving, or the panel button, restarts the indicator
  wire [2*VCR_SW_BITS-1:0] sw_now = pin_sync_q[2*VCR_SW_BITS-1:0];
  wire panel_reset = pin_sync_q[2*VCR_SW_BITS];
  wire cfg_change = sw_armed_q[SW_SETTLE-1] && (sw_now != sw_prev_q);
  wire restart = cfg_change || panel_reset;

  // unit address from the low bits of bank one; bank two only watched
  wire [VCR_UNIT_W-1:0] unit_addr = sw_now[VCR_UNIT_W-1:0];
  wire [VCR_IDX_W-1:0] base_idx = {unit_addr, {VCR_CH_W{1'b0}}} + VCR_GIDX_FIRST;
  wire [VCR_IDX_W:0] end_idx = {1'b0, base_idx} + VCR_SPAN;

  // command classification
  wire func_known = (i_cmd_func != VCR_FN_NONE);
  wire cmd_ok = i_cmd_valid && i_cmd_good && func_known;
  wire [VCR_IDX_W:0] idx_ext = {1'b0, i_cmd_global_channel_index};
  wire at_or_above = (i_cmd_global_channel_index >= base_idx);
  wire beyond = cmd_ok && (idx_ext >= end_idx);
  wire here = cmd_ok && at_or_above && !(idx_ext >= end_idx);
  wire [VCR_IDX_W-1:0] rel_full = i_cmd_global_channel_index - base_idx;
  wire [VCR_CH_W-1:0] rel_ch = rel_full[VCR_CH_W-1:0];
  wire to_relay = here && (rel_ch == VCR_RELAY_CH);
  wire relay_on = to_relay && (i_cmd_func == VCR_FN_PLAY);
  wire relay_off = to_relay && (i_cmd_func == VCR_FN_STOP);

  // downstream forward stage: one registered copy of the command
  logic fwd_valid_q;
  logic [VCR_IDX_W-1:0] fwd_idx_q;
  logic [VCR_FN_W-1:0] fwd_func_q;

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      fwd_valid_q <= 1'b0;
      fwd_idx_q <= '0;
      fwd_func_q <= '0;
    end else begin
      fwd_valid_q <= beyond;
      if (beyond) begin
        fwd_idx_q <= i_cmd_global_channel_index;
        fwd_func_q <= i_cmd_func;
      end
    end
  end

  // per-channel strobe decode; one register for the bank keeps a single writer
  wire [VCR_CHANNELS-1:0] strobe_hit;
  logic [VCR_CHANNELS-1:0] strobe_q;
  genvar g;
  generate
    for (g = 0; g < VCR_CHANNELS; g++) begin : g_chan
      assign strobe_hit[g] = here && (rel_ch == VCR_CH_W'(g));
    end
  endgenerate

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      strobe_q <= '0;
    end else begin
      strobe_q <= strobe_hit;
    end
  end

  // shared function code held for the analog drive; relay latched state
  logic [VCR_FN_W-1:0] func_q;
  logic relay_q;
  logic power_q;

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      func_q <= VCR_FN_NONE;
      relay_q <= 1'b0;
      power_q <= 1'b1;
    end else begin
      if (here) begin
        func_q <= i_cmd_func;
      end
      if (relay_on) begin
        relay_q <= 1'b1;
      end else if (relay_off) begin
        relay_q <= 1'b0;
      end
      power_q <= 1'b1;
    end
  end

  // indicator timing lives apart; only local accepts reach it
  logic awaiting;
  vcr_indicator #(
    .BLINK_CYC(BLINK_CYC),
    .PULSE_CYC(PULSE_CYC)
  ) u_indicator (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_restart(restart),
    .i_accept(here),
    .o_led(o_data_led),
    .o_awaiting(awaiting)
  );

  assign o_fwd_valid = fwd_valid_q;
  assign o_fwd_global_channel_index = fwd_idx_q;
  assign o_fwd_func = fwd_func_q;
  assign o_vcr_strobe = strobe_q;
  assign o_vcr_func = func_q;
  assign o_relay = relay_q;
  assign o_power_led = power_q;

  // checks on forwarding, relay and channel decode
  a_fwd_beyond: assert property (@(posedge i_clock) disable iff (i_rst)
    beyond |=> o_fwd_valid && (o_fwd_global_channel_index == $past(i_cmd_global_channel_index))
      && (o_fwd_func == $past(i_cmd_func))) else $error("command not forwarded");
  a_fwd_not_local: assert property (@(posedge i_clock) disable iff (i_rst)
    beyond |=> (o_vcr_strobe == '0)) else $error("forwarded command acted on");
  a_led_local_only: assert property (@(posedge i_clock) disable iff (i_rst)
    !here && !awaiting && !o_data_led && !restart |=> !o_data_led)
    else $error("led lit by non-local traffic");
  a_power_on: assert property (@(posedge i_clock) disable iff (i_rst)
    o_power_led) else $error("power led off");
  a_relay_cause: assert property (@(posedge i_clock) disable iff (i_rst)
    $rose(o_relay) |-> $past(relay_on)) else $error("relay moved uncommanded");
  a_relay_play: assert property (@(posedge i_clock) disable iff (i_rst)
    relay_on |=> o_relay ##1 ($stable(o_relay) || $past(relay_off)))
    else $error("play did not energize");
  a_relay_stop: assert property (@(posedge i_clock) disable iff (i_rst)
    relay_off |=> !o_relay) else $error("stop did not release");
  a_strobe_one: assert property (@(posedge i_clock) disable iff (i_rst)
    here |=> (o_vcr_strobe == (64'h1 << $past(rel_ch))) && (o_vcr_func == $past(i_cmd_func)))
    else $error("wrong channel strobed");
  a_unit_window: assert property (@(posedge i_clock) disable iff (i_rst)
    here |-> (rel_full < VCR_IDX_W'(VCR_CHANNELS))) else $error("index outside unit");
  a_invalid_drop: assert property (@(posedge i_clock) disable iff (i_rst)
    i_cmd_valid && !cmd_ok |=> !o_fwd_valid && (o_vcr_strobe == '0))
    else $error("bad command used");
  a_cfg_restart: assert property (@(posedge i_clock) disable iff (i_rst)
    cfg_change |=> awaiting) else $error("switch change kept state");

  c_local_cmd: cover property (@(posedge i_clock) disable iff (i_rst) here);
  c_forward: cover property (@(posedge i_clock) disable iff (i_rst) beyond);
  c_relay_cycle: cover property (@(posedge i_clock) disable iff (i_rst)
    relay_on ##[1:20] relay_off);

endmodule

// File: vcr_ctrl_model.sv
`timescale 1ns/100ps
module vcr_ctrl_model
  import vcr_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_req,
  input wire logic i_good,
  input wire logic [VCR_UNIT_W-1:0] i_unit,
  input wire logic [VCR_CH_W-1:0] i_ch,
  input wire logic [VCR_FN_W-1:0] i_func,
  output logic o_cmd_valid,
  output logic o_cmd_good,
  output logic [VCR_IDX_W-1:0] o_cmd_global_channel_index,
  output logic [VCR_FN_W-1:0] o_cmd_func
);
  // blocks of 64 indices per unit, first unit starts at one
  wire logic [VCR_IDX_W-1:0] gidx = {i_unit, i_ch} + VCR_GIDX_FIRST;
  logic junk = 1'b0;
  // idle lines flip every cycle so stale data never looks valid
  always @(negedge i_clock) begin
    junk <= ~junk;
  end
  // a request passes straight through: it stands from one falling edge to the
  // next, with no race against the bench that raised it on the same edge
  assign o_cmd_valid = i_req;
  assign o_cmd_good = i_req ? i_good : junk;
  assign o_cmd_global_channel_index = i_req ? gidx : {VCR_IDX_W{junk}};
  assign o_cmd_func = i_req ? i_func : {VCR_FN_W{junk}};
endmodule

// File: tb.sv
`timescale 1ns/100ps
module tb;
  import vcr_pkg::*;
  localparam int unsigned BLINK = 16;
  localparam int unsigned PULSE = 4;
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic panel = 1'b0;
  logic req = 1'b0;
  logic good = 1'b0;
  logic [VCR_SW_BITS-1:0] sw1 = 10'h000;
  logic [VCR_SW_BITS-1:0] sw2 = 10'h000;
  logic [VCR_UNIT_W-1:0] unit = '0;
  logic [VCR_UNIT_W-1:0] own;
  logic [VCR_CH_W-1:0] ch = '0;
  logic [VCR_FN_W-1:0] fn = '0;
  logic cv, cg, fv, relay, pled, dled;
  logic [VCR_IDX_W-1:0] cidx, fidx, e_fidx;
  logic [VCR_FN_W-1:0] cfn, ffn, vfn, e_ffn, e_vfn;
  logic [VCR_CHANNELS-1:0] strobe;
  logic e_relay;
  logic [31:0] r;
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;
  int seed = 32'h01da707e;
  int rel;

  vcr_ctrl_model i_vcr_ctrl_model (.i_clock(i_clock), .i_req(req), .i_good(good),
    .i_unit(unit), .i_ch(ch), .i_func(fn), .o_cmd_valid(cv), .o_cmd_good(cg),
    .o_cmd_global_channel_index(cidx), .o_cmd_func(cfn));
  vcr_relay_top #(.BLINK_CYC(BLINK), .PULSE_CYC(PULSE)) i_vcr_relay_top (
    .i_clock(i_clock), .i_rst(i_rst), .i_sw_bank1(sw1), .i_sw_bank2(sw2),
    .i_panel_reset(panel), .i_cmd_valid(cv), .i_cmd_good(cg),
    .i_cmd_global_channel_index(cidx), .i_cmd_func(cfn), .o_fwd_valid(fv),
    .o_fwd_global_channel_index(fidx), .o_fwd_func(ffn), .o_vcr_strobe(strobe),
    .o_vcr_func(vfn), .o_relay(relay), .o_power_led(pled), .o_data_led(dled));

  always #2 i_clock = ~i_clock;

  // cut a hang short well past the expected run length
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 8000) begin
      fail_count++;
      conclude();
    end
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      fail_count++;
    end
  endtask

  // 1 local, 2 forwarded, 0 dropped
  function automatic logic [1:0] kind(input int rl, input logic [2:0] f, input logic g);
    if (!g || f == 3'h0) return 2'h0;
    if (rl == 0) return 2'h1;
    if (rl == 1) return 2'h2;
    return 2'h0;
  endfunction

  // toggles over a window; half period BLINK gives three to five in 64 cycles
  task automatic blink_ok(input int lo, input int hi);
    int n;
    logic p;
    n = 0;
    p = dled;
    repeat (64) begin
      @(negedge i_clock);
      if (dled !== p) n++;
      p = dled;
    end
    chk(64'(n >= lo && n <= hi), 64'h1);
  endtask

  task automatic cmd(input int rl, input logic [5:0] c, input logic [2:0] f, input logic g);
    logic [1:0] k;
    k = kind(rl, f, g);
    @(negedge i_clock);
    req = 1'b1;
    good = g;
    unit = 6'(int'(own) + rl);
    ch = c;
    fn = f;
    // the answer stands for one cycle from the edge that took the request
    @(negedge i_clock);
    req = 1'b0;
    if (k == 2'h1) e_vfn = f;
    if (k == 2'h1 && c == VCR_RELAY_CH && f == VCR_FN_PLAY) e_relay = 1'b1;
    if (k == 2'h1 && c == VCR_RELAY_CH && f == VCR_FN_STOP) e_relay = 1'b0;
    if (k == 2'h2) e_fidx = {unit, c} + VCR_GIDX_FIRST;
    if (k == 2'h2) e_ffn = f;
    chk(strobe, (k == 2'h1) ? (64'h1 << c) : 64'h0);
    chk(fv, k == 2'h2);
    chk({fidx, ffn}, {e_fidx, e_ffn});
    chk(vfn, e_vfn);
    chk(relay, e_relay);
    chk(dled, k == 2'h1);
    repeat (PULSE - 1) @(negedge i_clock);
    chk(64'({fv, |strobe}), 64'h0);
    chk(dled, k == 2'h1);
    @(negedge i_clock);
    chk(dled, 1'b0);
  endtask

  task automatic power_up();
    i_rst = 1'b1;
    e_relay = 1'b0;
    e_fidx = '0;
    e_ffn = '0;
    e_vfn = '0;
    repeat (8) @(negedge i_clock);
    chk({pled, relay, dled}, 3'h5);
    i_rst = 1'b0;
    repeat (6) @(negedge i_clock);
    blink_ok(3, 5);
    $display("test power_up done");
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    r = $random(seed);
    own = 6'h01 + 6'(r[5:0] % 6'h3E);
    sw1 = {4'hA, own};
    sw2 = r[25:16];
    power_up();
    // corner cases first: relay play, forward, relay stop, below range
    cmd(0, 6'h3F, VCR_FN_PLAY, 1'b1);
    cmd(1, 6'h05, VCR_FN_PLAY, 1'b1);
    cmd(0, 6'h3F, VCR_FN_STOP, 1'b1);
    cmd(-1, 6'h00, VCR_FN_PLAY, 1'b1);
    for (int i = 0; i < 48; i++) begin
      r = $random(seed);
      rel = (r[1:0] == 2'h3) ? -1 : ((r[1:0] == 2'h2) ? 1 : 0);
      cmd(rel, r[8] ? 6'h3F : r[14:9], 3'(i), r[4:2] != 3'h0);
    end
    $display("test commands done");
    @(negedge i_clock);
    panel = 1'b1;
    repeat (8) @(negedge i_clock);
    chk(dled, 1'b1);
    panel = 1'b0;
    blink_ok(3, 5);
    cmd(0, 6'h01, VCR_FN_PAUSE, 1'b1);
    blink_ok(0, 0);
    sw2 = ~sw2;
    repeat (4) @(negedge i_clock);
    blink_ok(3, 5);
    $display("test restart done");
    power_up();
    conclude();
  end
endmodule
